//--- rtl/iefc_core.sv
// Interrupt enable and flag control register with event capture and request output.
//
// How it works
// - One 8-bit control register, readable and writable, holding enables and flags.
// - Flags set on their events whatever the enable bits hold.
// - Bit 7 is the global enable gating every request on core_irq_req; the irq output is not gated by it.
// - Bit 6 enables the peripheral group; clear disables peripheral requests on core_irq_req only, not on irq.
// - Bit 5 enables the timer-zero overflow interrupt.
// - Bit 4 enables the external pin interrupt.
// - Bit 2 sets on timer-zero overflow and holds until software clears it.
// - Bit 0 sets when any of four upper port pins changes state.
// - Upper seven bits reset to zero; port-change flag keeps its value on reset.
// - Control register appears at four bank addresses, one physical register.
`timescale 1ns/100ps

module iefc_core
  import iefc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire iefc_req_s bus_req,
  output logic [DATA_W-1:0] rdata,
  input wire logic timer_zero_overflow,
  input wire logic external_irq_pin,
  input wire logic external_edge_rising,
  input wire logic [PORT_CHANGE_PINS-1:0] port_change_pins,
  input wire logic peripheral_irq,
  output logic core_irq_req,
  output logic irq
);

  logic [DATA_W-1:1] ctrl_hi_q;
  logic port_flag_q;
  logic [DATA_W-1:0] ctrl_value;
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] mask_q;
  logic [2:0] ext_sync_q;
  logic [2:0] port_sync_q [PORT_CHANGE_PINS];
  logic [PORT_CHANGE_PINS-1:0] port_ref_q;
  iefc_state_e state_q;
  logic ctrl_hit;
  logic wr_ctrl;
  logic ext_edge;
  logic port_changed;
  logic [EV_COUNT-1:0] events;

  // Bank mirror decode.
  // four bank aliases
  assign ctrl_hit = (bus_req.addr == INTERRUPT_CONTROL_BANK0) ||
                    (bus_req.addr == INTERRUPT_CONTROL_BANK1) ||
                    (bus_req.addr == INTERRUPT_CONTROL_BANK2) ||
                    (bus_req.addr == INTERRUPT_CONTROL_BANK3);
  assign wr_ctrl = bus_req.wr && ctrl_hit;

  // External pin synchroniser; edge judged only on the second and third stages.
  // It is not reset, so a pin held high across reset does not look like a new edge.
  always_ff @(posedge core_clk) begin
    ext_sync_q <= {ext_sync_q[1:0], external_irq_pin};
  end

  assign ext_edge = external_edge_rising ? (ext_sync_q[1] && !ext_sync_q[2])
                                         : (!ext_sync_q[1] && ext_sync_q[2]);

  // Port pins pass three stages each, one generate block per pin.
  genvar gi;
  generate
    for (gi = 0; gi < PORT_CHANGE_PINS; gi++) begin : g_port
      always_ff @(posedge core_clk) begin
        port_sync_q[gi] <= {port_sync_q[gi][1:0], port_change_pins[gi]};
      end
    end
  endgenerate

  // Port changes count only from the cycle after reset, once the state moves to IEFC_RUN.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= IEFC_ARM;
    end else begin
      state_q <= IEFC_RUN;
    end
  end

  // The reference follows the pins through reset, so levels held across reset are no change.
  always_ff @(posedge core_clk) begin
    port_ref_q <= port_changed_mask();
  end

  // A pin counts as changed only when its second and third stages agree.
  function automatic logic [PORT_CHANGE_PINS-1:0] port_changed_mask();
    logic [PORT_CHANGE_PINS-1:0] m;
    m = port_ref_q;
    for (int i = 0; i < PORT_CHANGE_PINS; i++) begin
      if (port_sync_q[i][1] == port_sync_q[i][2]) begin
        m[i] = port_sync_q[i][1];
      end
    end
    return m;
  endfunction : port_changed_mask

  assign port_changed = (state_q == IEFC_RUN) && (port_changed_mask() != port_ref_q);

  // Control register: writes store all bits, hardware events set flags and win over clears.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_hi_q <= CONTROL_UPPER_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_hi_q <= bus_req.wdata[7:1];
      end
      if (timer_zero_overflow) begin
        ctrl_hi_q[TIMER_ZERO_OVERFLOW_FLAG_BIT] <= 1'b1;
      end
      if (ext_edge) begin
        ctrl_hi_q[EXTERNAL_PIN_IRQ_FLAG_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_ctrl) begin
      port_flag_q <= bus_req.wdata[PORT_CHANGE_IRQ_FLAG_BIT];
    end
    if (!rst && port_changed) begin
      port_flag_q <= 1'b1;
    end
  end

  assign ctrl_value = {ctrl_hi_q, port_flag_q};

  assign core_irq_req = ctrl_value[GLOBAL_IRQ_ENABLE_BIT] && (
      (ctrl_value[TIMER_ZERO_OVERFLOW_ENABLE_BIT] && ctrl_value[TIMER_ZERO_OVERFLOW_FLAG_BIT]) ||
      (ctrl_value[EXTERNAL_PIN_IRQ_ENABLE_BIT] && ctrl_value[EXTERNAL_PIN_IRQ_FLAG_BIT]) ||
      (ctrl_value[PORT_CHANGE_IRQ_ENABLE_BIT] && ctrl_value[PORT_CHANGE_IRQ_FLAG_BIT]) ||
      (ctrl_value[PERIPHERAL_GROUP_ENABLE_BIT] && peripheral_irq));

  assign events[EV_TIMER] = timer_zero_overflow;
  assign events[EV_EXT] = ext_edge;
  assign events[EV_PORT] = port_changed;
  assign events[EV_PERIPH] = peripheral_irq;

  // Sticky event status, cleared by a read; an event in the read cycle survives.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= ((bus_req.rd && bus_req.addr == IRQ_STATUS_ADDR) ? '0 : status_q) |
                  {{(DATA_W-EV_COUNT){1'b0}}, events};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_q <= IRQ_MASK_RESET;
    end else if (bus_req.wr && bus_req.addr == IRQ_MASK_ADDR) begin
      mask_q <= bus_req.wdata;
    end
  end

  assign irq = |(status_q & mask_q);

  // Read data stand one cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (bus_req.rd) begin
      if (ctrl_hit) begin
        rdata <= ctrl_value;
      end else if (bus_req.addr == IRQ_STATUS_ADDR) begin
        rdata <= status_q;
      end else if (bus_req.addr == IRQ_MASK_ADDR) begin
        rdata <= mask_q;
      end else begin
        rdata <= '0;
      end
    end else begin
      rdata <= '0;
    end
  end

endmodule : iefc_core

//--- rtl/iefc_pkg.sv
// Package with register map, bit positions and shared types of the interrupt control block.
package iefc_pkg;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] INTERRUPT_CONTROL_BANK0 = 9'h00B;
  localparam logic [ADDR_W-1:0] INTERRUPT_CONTROL_BANK1 = 9'h08B;
  localparam logic [ADDR_W-1:0] INTERRUPT_CONTROL_BANK2 = 9'h10B;
  localparam logic [ADDR_W-1:0] INTERRUPT_CONTROL_BANK3 = 9'h18B;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 9'h1F0;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 9'h1F1;

  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
  localparam int TIMER_ZERO_OVERFLOW_ENABLE_BIT = 5;
  localparam int EXTERNAL_PIN_IRQ_ENABLE_BIT = 4;
  localparam int PORT_CHANGE_IRQ_ENABLE_BIT = 3;
  localparam int TIMER_ZERO_OVERFLOW_FLAG_BIT = 2;
  localparam int EXTERNAL_PIN_IRQ_FLAG_BIT = 1;
  localparam int PORT_CHANGE_IRQ_FLAG_BIT = 0;

  localparam logic [6:0] CONTROL_UPPER_RESET = 7'h00;
  localparam logic [DATA_W-1:0] IRQ_MASK_RESET = 8'h00;
  localparam int PORT_CHANGE_PINS = 4;

  localparam int EV_TIMER = 0;
  localparam int EV_EXT = 1;
  localparam int EV_PORT = 2;
  localparam int EV_PERIPH = 3;
  localparam int EV_COUNT = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } iefc_req_s;

  typedef enum logic [1:0] {
    IEFC_ARM = 2'b00,
    IEFC_RUN = 2'b01
  } iefc_state_e;

endpackage : iefc_pkg

//--- sim/iefc_checker.sv
// Port checks for the interrupt control block.
`timescale 1ns/100ps
module iefc_checker
  import iefc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire iefc_req_s bus_req,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic timer_zero_overflow,
  input wire logic peripheral_irq,
  input wire logic core_irq_req,
  input wire logic irq
);
  logic ctl_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk) begin
    ctl_q <= !rst && bus_req.rd && bus_req.addr == INTERRUPT_CONTROL_BANK0;
  end
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  a_gie_off: assert property (ctl_q && !rdata[7] |-> !core_irq_req)
    else $error("request without global enable");
  a_periph_req: assert property (ctl_q && rdata[7:6] == 2'b11 && peripheral_irq |-> core_irq_req)
    else $error("peripheral request missing");
  a_timer_req: assert property (ctl_q && rdata[7] && rdata[5] && rdata[2] |-> core_irq_req)
    else $error("timer request missing");
  a_ext_req: assert property (ctl_q && rdata[7] && rdata[4] && rdata[1] |-> core_irq_req)
    else $error("pin request missing");
  a_port_req: assert property (ctl_q && rdata[7] && rdata[3] && rdata[0] |-> core_irq_req)
    else $error("port request missing");
  a_reset_quiet: assert property ($past(rst) |-> !core_irq_req && !irq)
    else $error("request after reset");
  a_timer_flag: assert property (timer_zero_overflow ##1 !bus_req.wr ##1
    (bus_req.rd && bus_req.addr == INTERRUPT_CONTROL_BANK0) |=> rdata[2])
    else $error("timer flag not set");
  cover property (ctl_q && core_irq_req);
  cover property (irq);
  cover property (timer_zero_overflow);
endmodule : iefc_checker

bind iefc_core iefc_checker chk (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
  .rdata(rdata), .timer_zero_overflow(timer_zero_overflow), .peripheral_irq(peripheral_irq),
  .core_irq_req(core_irq_req), .irq(irq));

//--- sim/iefc_source.sv
// Event source model: timer overflow pulse, external pin, port pins, peripheral level.
`timescale 1ns/100ps
module iefc_source (
  input wire logic core_clk,
  output logic timer_zero_overflow,
  output logic external_irq_pin,
  output logic [3:0] port_change_pins,
  output logic peripheral_irq
);
  initial begin
    timer_zero_overflow = 1'b0;
    external_irq_pin = 1'b0;
    port_change_pins = 4'h0;
    peripheral_irq = 1'b0;
  end
  task automatic overflow();
    @(posedge core_clk);
    timer_zero_overflow <= 1'b1;
    @(posedge core_clk);
    timer_zero_overflow <= 1'b0;
  endtask : overflow
  task automatic drive(input logic e, input logic [3:0] p, input logic q);
    @(posedge core_clk);
    external_irq_pin <= e;
    port_change_pins <= p;
    peripheral_irq <= q;
  endtask : drive
endmodule : iefc_source

//--- sim/iefc_core_tb.sv
// Self-checking bench for the interrupt control block.
`timescale 1ns/100ps
module iefc_core_tb
  import iefc_pkg::*;
;
  logic core_clk, rst, edge_rising, tov, ext, per, core_irq_req, irq;
  logic [3:0] pins;
  iefc_req_s bus_req;
  logic [7:0] rdata;
  logic [8:0] banks [4] = '{9'h00B, 9'h08B, 9'h10B, 9'h18B};
  int fail_count, checks;
  iefc_source src (.core_clk(core_clk), .timer_zero_overflow(tov), .external_irq_pin(ext),
    .port_change_pins(pins), .peripheral_irq(per));
  iefc_core dut (.core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .timer_zero_overflow(tov), .external_irq_pin(ext), .external_edge_rising(edge_rising),
    .port_change_pins(pins), .peripheral_irq(per), .core_irq_req(core_irq_req), .irq(irq));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    rst = 1'b1;
    bus_req = '0;
    edge_rising = 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(banks[i], 8'h10 << i);
      rd(banks[(i + 1) % 4], 8'h10 << i);
    end
    rd(9'h050, 8'h00);
    $display("test registers done");
    wr(banks[1], 8'h00);
    src.overflow();
    rd(banks[0], 8'h04);
    src.drive(1'b1, 4'h0, 1'b0);
    repeat (5) @(posedge core_clk);
    rd(banks[0], 8'h06);
    src.drive(1'b1, 4'h8, 1'b0);
    repeat (5) @(posedge core_clk);
    rd(banks[0], 8'h07);
    chk({7'h00, core_irq_req | irq}, 8'h00);
    rd(IRQ_STATUS_ADDR, 8'h07);
    rd(IRQ_STATUS_ADDR, 8'h00);
    $display("test flags done");
    for (int i = 3; i < 6; i++) begin
      wr(banks[2], 8'h87 | (8'h01 << i));
      rd(banks[0], 8'h87 | (8'h01 << i));
      chk({7'h00, core_irq_req}, 8'h01);
    end
    wr(banks[0], 8'h87);
    src.drive(1'b1, 4'h8, 1'b1);
    #1 chk({7'h00, core_irq_req}, 8'h00);
    wr(banks[0], 8'hC7);
    rd(banks[0], 8'hC7);
    chk({7'h00, core_irq_req}, 8'h01);
    wr(banks[0], 8'h47);
    #1 chk({7'h00, core_irq_req}, 8'h00);
    src.drive(1'b1, 4'h8, 1'b0);
    rd(IRQ_STATUS_ADDR, 8'h08);
    $display("test enables done");
    wr(IRQ_MASK_ADDR, 8'h01);
    rd(IRQ_MASK_ADDR, 8'h01);
    src.overflow();
    for (int n = 0; n < 10 && irq !== 1'b1; n++) @(posedge core_clk);
    chk({7'h00, irq}, 8'h01);
    if (irq !== 1'b1) end_of_test();
    rd(IRQ_STATUS_ADDR, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(banks[3], 8'h00);
    rd(banks[0], 8'h00);
    edge_rising <= 1'b0;
    src.drive(1'b0, 4'h8, 1'b0);
    repeat (5) @(posedge core_clk);
    rd(banks[0], 8'h02);
    $display("test mask done");
    wr(banks[0], 8'hF9);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    rd(banks[0], 8'h01);
    $display("test reset done");
    end_of_test();
  end
endmodule : iefc_core_tb
